// *** bench/ipmmu_ram_model.sv ***
// ram array stand-in answering one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module ipmmu_ram_model import ipmmu_pkg::*; #(
    parameter logic [3:0] TAG = 4'ha
) (
    input wire logic clock,
    input wire ipmmu_ram_type ram,
    output logic [31:0] rdata
);
    logic [31:0] mem [32768];
    logic [32767:0] used = '0;
    logic [31:0] held = 32'h0;
    logic [31:0] noise = 32'h0;
    logic shown = 1'b0;
    // outside the answer cycle the data keep moving, never a stale word
    always @(posedge clock) begin
        noise <= noise + 32'h9e37_79b9;
        shown <= ram.req;
        if (ram.req) begin
            if (ram.wr) begin
                mem[ram.addr[16:2]] <= ram.wdata;
                used[ram.addr[16:2]] <= 1'b1;
            end
            held <= used[ram.addr[16:2]] ? mem[ram.addr[16:2]]
                : {TAG, 11'h0, ram.addr[16:2], 2'h0};
        end
    end
    assign rdata = shown ? held : noise;
endmodule
`default_nettype wire

// *** bench/ipmmu_test.sv ***
// random and corner stimulus for the ram page unit with self checks
`timescale 1ns/1ps
`default_nettype none
module ipmmu_test import ipmmu_pkg::*;;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] reg_pid = 3'h0;
    logic [31:0] reg_rdata;
    logic [2:0] cpu0_pid = 3'h0;
    logic [2:0] cpu1_pid = 3'h0;
    ipmmu_bus_req_type ibus_req = '0;
    ipmmu_bus_req_type dbus_req = '0;
    ipmmu_bus_resp_type ibus_resp;
    ipmmu_bus_resp_type dbus_resp;
    ipmmu_ram_type iram;
    ipmmu_ram_type dram;
    logic [31:0] iram_rdata;
    logic [31:0] dram_rdata;
    integer seed = 39;
    int miscompares = 0;
    int num_checks = 0;
    logic [1:0] mode [2];
    logic [6:0] tab [2][16];
    logic [31:0] shadow [logic [15:0]];
    logic [17:0] last_deny = 18'h0;

    ipmmu_top u_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_pid(reg_pid), .reg_rdata(reg_rdata), .cpu0_pid(cpu0_pid),
        .cpu1_pid(cpu1_pid), .ibus_req(ibus_req), .ibus_resp(ibus_resp),
        .iram(iram), .iram_rdata(iram_rdata), .dbus_req(dbus_req),
        .dbus_resp(dbus_resp), .dram(dram), .dram_rdata(dram_rdata));
    ipmmu_ram_model #(.TAG(4'ha)) u_iram (.clock(clock), .ram(iram),
        .rdata(iram_rdata));
    ipmmu_ram_model #(.TAG(4'h5)) u_dram (.clock(clock), .ram(dram),
        .rdata(dram_rdata));

    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reg_access(input logic [7:0] a, input logic wr,
            input logic [31:0] d, input logic [2:0] own);
        @(posedge clock);
        reg_addr <= a;
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_wdata <= d;
        reg_pid <= own;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    // returns the allow bit above the physical offset
    function automatic logic [17:0] expect_pa(input int s,
            input logic [2:0] own, input logic [31:0] a, input logic wr);
        logic [31:0] off;
        logic [2:0] pm;
        int sh;
        int vp;
        off = a - (s ? INSTR_BASE : DATA_BASE);
        sh = 13 - int'(mode[s]);
        vp = int'(off >> sh);
        if (off >= 32'h20000) begin
            return 18'h0;
        end
        if (own < 3'h2) begin
            return {1'b1, off[16:0]};
        end
        // remainder is shut to ids 2 to 7, so no ram address goes out
        if (vp >= 16) begin
            return 18'h0;
        end
        if (s == 1 && wr) begin
            return 18'h0;
        end
        for (int p = 0; p < 16; p++) begin
            pm = tab[s][p][6:4];
            if (int'(tab[s][p][3:0]) == vp
                    && (pm == 3'h1 || (pm >= 3'h2 && pm == own))) begin
                return {1'b1, 17'(p << sh) | (off[16:0] & 17'((1 << sh) - 1))};
            end
        end
        return 18'h0;
    endfunction

    task automatic access(input int s);
        ipmmu_bus_req_type rq;
        ipmmu_bus_resp_type rs;
        logic [2:0] p0;
        logic [2:0] p1;
        logic [17:0] ex;
        logic [31:0] exd;
        logic [15:0] k;
        logic [16:0] ra;
        logic saw;
        int n;
        p0 = 3'($random(seed));
        p1 = 3'($random(seed));
        rq.valid = 1'b1;
        rq.wr = 1'($random(seed));
        rq.cpu = 1'($random(seed));
        rq.wdata = $random(seed);
        rq.addr = (s ? INSTR_BASE : DATA_BASE) + (32'($random(seed)) & 32'h1fffc);
        if (($random(seed) & 7) == 0) begin
            rq.addr = rq.addr ^ 32'h0004_0000;
        end
        ex = expect_pa(s, rq.cpu ? p1 : p0, rq.addr, rq.wr);
        k = {1'(s), ex[16:2]};
        exd = 32'h0;
        if (ex[17] && !rq.wr) begin
            exd = shadow.exists(k) ? shadow[k]
                : {s ? 4'ha : 4'h5, 11'h0, ex[16:2], 2'h0};
        end
        @(posedge clock);
        cpu0_pid <= p0;
        cpu1_pid <= p1;
        if (s == 1) begin
            ibus_req <= rq;
        end else begin
            dbus_req <= rq;
        end
        saw = 1'b0;
        ra = 17'h0;
        n = 0;
        do begin
            @(posedge clock);
            ibus_req.valid <= 1'b0;
            dbus_req.valid <= 1'b0;
            #1;
            n++;
            rs = s ? ibus_resp : dbus_resp;
            if (s ? iram.req : dram.req) begin
                saw = 1'b1;
                ra = s ? iram.addr : dram.addr;
            end
        end while (rs.ack !== 1'b1 && n < 6);
        check("latency", 32'(n), 32'd3);
        check("fault", 32'(rs.fault), 32'(!ex[17]));
        check("ramreq", 32'(saw), 32'(ex[17]));
        check("ramaddr", 32'(ra), 32'(ex[16:0]));
        check("rdata", rs.rdata, exd);
        if (ex[17] && rq.wr) begin
            shadow[k] = rq.wdata;
        end
        if (!ex[17]) begin
            last_deny = {1'(s), rq.addr[16:0]};
        end
    endtask

    initial begin
        logic [7:0] ra [6] = '{8'h00, 8'h3c, 8'h7c, 8'h80, 8'h84, 8'hfc};
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            reg_access(ra[i], 1'b0, 32'h0, 3'h0);
            check("reset value", reg_rdata, 32'h0);
        end
        $display("reset values done");
        // cleared tables: ids 2 to 7 find no permitting entry at all
        for (int s = 0; s < 2; s++) begin
            mode[s] = 2'h0;
            for (int p = 0; p < 16; p++) begin
                tab[s][p] = 7'h0;
            end
        end
        for (int i = 0; i < 40; i++) begin
            access(i & 1);
        end
        $display("empty table done");
        for (int r = 0; r < 6; r++) begin
            for (int s = 0; s < 2; s++) begin
                mode[s] = 2'((r + s) % 3);
                reg_access(s ? 8'h80 : 8'h84, 1'b1, 32'(mode[s]), 3'(r & 1));
                for (int p = 0; p < 16; p++) begin
                    tab[s][p] = 7'($random(seed));
                    reg_access(8'((s ? 0 : 64) + 4 * p), 1'b1,
                        32'(tab[s][p]), 3'($random(seed) & 1));
                end
                // a lower-privilege writer must leave the table untouched
                reg_access(s ? 8'h00 : 8'h40, 1'b1, 32'h7f, 3'h2 + 3'(r));
                reg_access(s ? 8'h80 : 8'h84, 1'b1,
                    32'((int'(mode[s]) + 1) % 3), 3'h2 + 3'(r));
                // code 3 names no page size and must leave the old one
                reg_access(s ? 8'h80 : 8'h84, 1'b1, 32'h3, 3'h0);
                reg_access(s ? 8'h00 : 8'h40, 1'b0, 32'h0, 3'h0);
                check("entry", reg_rdata, 32'(tab[s][0]));
                reg_access(s ? 8'h80 : 8'h84, 1'b0, 32'h0, 3'h0);
                check("size", reg_rdata, 32'(mode[s]));
            end
            for (int i = 0; i < 80; i++) begin
                access(i & 1);
            end
            reg_access(8'h88, 1'b0, 32'h0, 3'h0);
            check("status", reg_rdata, 32'(last_deny));
            $display("round %0d done", r);
        end
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire

// *** design/ipmmu_pid_sel.sv ***
// picks the owner id of the cpu that issued an access
`timescale 1ns/1ps
`default_nettype none
module ipmmu_pid_sel import ipmmu_pkg::*; (
    input wire logic [2:0] cpu0_pid,
    input wire logic [2:0] cpu1_pid,
    input wire logic cpu,
    output logic [2:0] pid
);
    always_comb begin
        pid = cpu ? cpu1_pid : cpu0_pid;
    end
endmodule
`default_nettype wire

// *** design/ipmmu_pkg.sv ***
// shared constants, types and helpers of the internal ram page unit
package ipmmu_pkg;

    localparam int NUM_PAGES = 16;
    localparam int REGION_BITS = 17;
    localparam logic [31:0] INSTR_BASE = 32'h4008_0000;
    localparam logic [31:0] DATA_BASE = 32'h3ffc_0000;

    // page size selector codes
    localparam logic [1:0] MODE_8K = 2'h0;
    localparam logic [1:0] MODE_4K = 2'h1;
    localparam logic [1:0] MODE_2K = 2'h2;
    localparam logic [4:0] SHIFT_8K = 5'hd;
    localparam logic [4:0] SHIFT_4K = 5'hc;
    localparam logic [4:0] SHIFT_2K = 5'hb;

    // map entry fields
    localparam int PERM_LSB = 4;
    localparam int PERM_MSB = 6;
    localparam int VPAGE_LSB = 0;
    localparam int VPAGE_MSB = 3;
    localparam logic [2:0] PERM_NONE = 3'h0;
    localparam logic [2:0] PERM_ALL = 3'h1;
    localparam logic [2:0] PRIV_LIMIT = 3'h2;

    // register word indexes, byte address is four times the index
    localparam logic [5:0] IDX_INSTR_MAP = 6'h00;
    localparam logic [5:0] IDX_DATA_MAP = 6'h10;
    localparam logic [5:0] IDX_INSTR_SIZE = 6'h20;
    localparam logic [5:0] IDX_DATA_SIZE = 6'h21;
    localparam logic [5:0] IDX_STATUS = 6'h22;

    localparam logic [6:0] ENTRY_RESET = 7'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;

    typedef struct packed {
        logic [2:0] perm;
        logic [3:0] vpage;
    } ipmmu_entry_type;

    typedef ipmmu_entry_type [NUM_PAGES-1:0] ipmmu_table_type;

    typedef struct packed {
        logic valid;
        logic wr;
        logic cpu;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ipmmu_bus_req_type;

    typedef struct packed {
        logic ack;
        logic fault;
        logic [31:0] rdata;
    } ipmmu_bus_resp_type;

    typedef struct packed {
        logic req;
        logic wr;
        logic [REGION_BITS-1:0] addr;
        logic [31:0] wdata;
    } ipmmu_ram_type;

    function automatic logic [4:0] ipmmu_page_shift(input logic [1:0] mode);
        logic [4:0] s;
        s = SHIFT_8K;
        if (mode == MODE_4K) begin
            s = SHIFT_4K;
        end else if (mode == MODE_2K) begin
            s = SHIFT_2K;
        end
        return s;
    endfunction

    function automatic logic ipmmu_perm_ok(input logic [2:0] perm,
                                          input logic [2:0] pid);
        return (perm == PERM_ALL) || (perm >= PRIV_LIMIT && perm == pid);
    endfunction

endpackage

// *** design/ipmmu_top.sv ***
// page translation and access control for the two upper ram regions
// Notes on behaviour
// - page size code 0 gives 8 KB, 1 gives 4 KB, 2 gives 2 KB.
// - instruction and data regions each have their own page size selector.
// - every region always has sixteen managed pages whatever the size.
// - beyond the sixteen pages the region is left untranslated.
// - untranslated remainder is open to ids 0 and 1 only.
// - page n starts at base plus page size times n.
// - sixteen map entries per region, indexed by physical page.
// - entry bits 6:4: 0 none, 1 all, 2 to 7 that id only.
// - entry bits 3:0 name the virtual page sent to this physical page.
// - ids 0 and 1 ignore the map, full access, page x to x.
// - map and size registers take writes only from ids 0 and 1.
// - instruction region on the instruction bus, data region on data bus.
// - ids 2 to 7 may only read the instruction region pages.
// - ids 2 to 7 may read and write permitted data region pages.
// - translation keeps the in-page offset, swaps only the page index.
// - the owner id comes from the issuing cpu's own id source.
`timescale 1ns/1ps
`default_nettype none
module ipmmu_top import ipmmu_pkg::*; (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [2:0] reg_pid,
    output logic [31:0] reg_rdata,
    input wire logic [2:0] cpu0_pid,
    input wire logic [2:0] cpu1_pid,
    input wire ipmmu_bus_req_type ibus_req,
    output ipmmu_bus_resp_type ibus_resp,
    output ipmmu_ram_type iram,
    input wire logic [31:0] iram_rdata,
    input wire ipmmu_bus_req_type dbus_req,
    output ipmmu_bus_resp_type dbus_resp,
    output ipmmu_ram_type dram,
    input wire logic [31:0] dram_rdata
);
    typedef struct packed {
        ipmmu_ram_type ram;
        logic s1_v;
        logic s1_deny;
        logic s1_rd;
        logic s2_v;
        logic s2_deny;
        logic s2_rd;
        ipmmu_bus_resp_type resp;
    } ipmmu_pipe_type;

    typedef struct packed {
        ipmmu_table_type itab;
        ipmmu_table_type dtab;
        logic [1:0] imode;
        logic [1:0] dmode;
        logic [31:0] rdata;
        logic [17:0] last_deny;
        ipmmu_pipe_type ip;
        ipmmu_pipe_type dp;
    } ipmmu_state_type;

    ipmmu_state_type st;
    ipmmu_state_type next_st;

    logic [2:0] i_pid;
    logic [2:0] d_pid;
    logic i_allow;
    logic d_allow;
    logic i_managed;
    logic d_managed;
    logic [REGION_BITS-1:0] i_phys;
    logic [REGION_BITS-1:0] d_phys;
    logic reg_priv;
    logic [5:0] reg_idx;
    logic [5:0] rd_idx;

    ipmmu_pid_sel u_ipid (
        .cpu0_pid(cpu0_pid),
        .cpu1_pid(cpu1_pid),
        .cpu(ibus_req.cpu),
        .pid(i_pid)
    );

    ipmmu_pid_sel u_dpid (
        .cpu0_pid(cpu0_pid),
        .cpu1_pid(cpu1_pid),
        .cpu(dbus_req.cpu),
        .pid(d_pid)
    );

    // instruction region is read only for unprivileged ids
    ipmmu_xlate #(.BASE(INSTR_BASE), .WRITE_OK(1'b0)) u_ixl (
        .mode(st.imode),
        .tab(st.itab),
        .pid(i_pid),
        .addr(ibus_req.addr),
        .wr(ibus_req.wr),
        .allow(i_allow),
        .managed(i_managed),
        .phys_addr(i_phys)
    );

    ipmmu_xlate #(.BASE(DATA_BASE), .WRITE_OK(1'b1)) u_dxl (
        .mode(st.dmode),
        .tab(st.dtab),
        .pid(d_pid),
        .addr(dbus_req.addr),
        .wr(dbus_req.wr),
        .allow(d_allow),
        .managed(d_managed),
        .phys_addr(d_phys)
    );

    // three stage answer: ram request, ram data, bus answer
    function automatic ipmmu_pipe_type pipe_step(
        input ipmmu_pipe_type p,
        input ipmmu_bus_req_type rq,
        input logic allow,
        input logic [REGION_BITS-1:0] pa,
        input logic [31:0] rd
    );
        ipmmu_pipe_type n;
        n = p;
        n.ram.req = rq.valid && allow;
        n.ram.wr = rq.valid && allow && rq.wr;
        n.ram.addr = (rq.valid && allow) ? pa : '0;
        n.ram.wdata = (rq.valid && allow && rq.wr) ? rq.wdata : '0;
        n.s1_v = rq.valid;
        n.s1_deny = !allow;
        n.s1_rd = !rq.wr;
        n.s2_v = p.s1_v;
        n.s2_deny = p.s1_deny;
        n.s2_rd = p.s1_rd;
        n.resp.ack = p.s2_v;
        n.resp.fault = p.s2_v && p.s2_deny;
        // a refused read must never see ram contents
        n.resp.rdata = (p.s2_v && !p.s2_deny && p.s2_rd) ? rd : '0;
        return n;
    endfunction

    always_comb begin
        next_st = st;
        reg_idx = reg_addr[7:2];
        rd_idx = reg_addr[7:2];
        reg_priv = (reg_pid < PRIV_LIMIT);
        next_st.ip = pipe_step(st.ip, ibus_req, i_allow, i_phys, iram_rdata);
        next_st.dp = pipe_step(st.dp, dbus_req, d_allow, d_phys, dram_rdata);
        if (ibus_req.valid && !i_allow) begin
            next_st.last_deny = {1'b1, ibus_req.addr[REGION_BITS-1:0]};
        end
        if (dbus_req.valid && !d_allow) begin
            next_st.last_deny = {1'b0, dbus_req.addr[REGION_BITS-1:0]};
        end
        // unprivileged writers are silently dropped
        if (reg_wr && reg_priv) begin
            if (reg_idx < IDX_DATA_MAP) begin
                next_st.itab[reg_idx[3:0]] = reg_wdata[PERM_MSB:VPAGE_LSB];
            end else if (reg_idx < IDX_INSTR_SIZE) begin
                next_st.dtab[reg_idx[3:0]] = reg_wdata[PERM_MSB:VPAGE_LSB];
            end else if (reg_idx == IDX_INSTR_SIZE) begin
                // code 3 is not a page size, keep the old one
                if (reg_wdata[1:0] <= MODE_2K) begin
                    next_st.imode = reg_wdata[1:0];
                end
            end else if (reg_idx == IDX_DATA_SIZE) begin
                if (reg_wdata[1:0] <= MODE_2K) begin
                    next_st.dmode = reg_wdata[1:0];
                end
            end
        end
        next_st.rdata = '0;
        if (reg_rd) begin
            if (rd_idx < IDX_DATA_MAP) begin
                next_st.rdata = {25'h0, st.itab[rd_idx[3:0]]};
            end else if (rd_idx < IDX_INSTR_SIZE) begin
                next_st.rdata = {25'h0, st.dtab[rd_idx[3:0]]};
            end else if (rd_idx == IDX_INSTR_SIZE) begin
                next_st.rdata = {30'h0, st.imode};
            end else if (rd_idx == IDX_DATA_SIZE) begin
                next_st.rdata = {30'h0, st.dmode};
            end else if (rd_idx == IDX_STATUS) begin
                next_st.rdata = {14'h0, st.last_deny};
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            for (int i = 0; i < NUM_PAGES; i++) begin
                st.itab[i] <= ENTRY_RESET;
                st.dtab[i] <= ENTRY_RESET;
            end
            st.imode <= MODE_RESET;
            st.dmode <= MODE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign ibus_resp = st.ip.resp;
    assign dbus_resp = st.dp.resp;
    assign iram = st.ip.ram;
    assign dram = st.dp.ram;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    property p_instr_wr_refused;
        ibus_req.valid && ibus_req.wr && i_pid >= 3'h2
            |=> !iram.req ##2 ibus_resp.ack && ibus_resp.fault;
    endproperty
    a_instr_wr_refused: assert property (p_instr_wr_refused)
        else $error("unprivileged instruction write not refused");

    property p_priv_identity;
        ibus_req.valid && i_pid < 3'h2
            && ibus_req.addr[31:17] == INSTR_BASE[31:17]
            |=> iram.req && iram.addr == $past(ibus_req.addr[16:0]);
    endproperty
    a_priv_identity: assert property (p_priv_identity)
        else $error("privileged access was translated or dropped");

    property p_reg_wr_blocked;
        reg_wr && reg_pid >= 3'h2
            |=> $stable(st.itab) && $stable(st.dtab)
                && $stable(st.imode) && $stable(st.dmode);
    endproperty
    a_reg_wr_blocked: assert property (p_reg_wr_blocked)
        else $error("unprivileged register write took effect");

    property p_deny_no_data;
        dbus_req.valid && !dbus_req.wr && !d_allow
            |=> !dram.req ##2 dbus_resp.ack && dbus_resp.rdata == 32'h0;
    endproperty
    a_deny_no_data: assert property (p_deny_no_data)
        else $error("refused read reached ram or returned data");

    property p_answer_time;
        dbus_req.valid |-> ##3 dbus_resp.ack;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("data bus answer not three cycles after request");

    property p_data_wr_ok;
        dbus_req.valid && dbus_req.wr && d_allow && d_pid >= 3'h2
            |=> dram.req && dram.wr && dram.wdata == $past(dbus_req.wdata);
    endproperty
    a_data_wr_ok: assert property (p_data_wr_ok)
        else $error("permitted data write not passed to ram");

    property p_unmanaged_deny;
        dbus_req.valid && d_pid >= 3'h2 && !d_managed |-> !d_allow;
    endproperty
    a_unmanaged_deny: assert property (p_unmanaged_deny)
        else $error("unprivileged access to the remainder allowed");

    property p_offset_kept;
        dbus_req.valid && d_allow && st.dmode == 2'h0
            |=> dram.addr[12:0] == $past(dbus_req.addr[12:0]);
    endproperty
    a_offset_kept: assert property (p_offset_kept)
        else $error("in-page offset changed by translation");

    property p_small_page_remainder;
        dbus_req.valid && st.dmode == 2'h2 && dbus_req.addr[16:15] != 2'h0
            |-> !d_managed;
    endproperty
    a_small_page_remainder: assert property (p_small_page_remainder)
        else $error("2 KB remainder treated as managed");

    property p_no_entry_deny;
        ibus_req.valid && i_pid >= 3'h2 && st.itab == '0 |=> !iram.req;
    endproperty
    a_no_entry_deny: assert property (p_no_entry_deny)
        else $error("access allowed with no permitting entry");

    property p_size_code_kept;
        reg_wr && reg_pid < PRIV_LIMIT && reg_addr[7:2] == IDX_INSTR_SIZE
            && reg_wdata[1:0] == 2'h3 |=> $stable(st.imode);
    endproperty
    a_size_code_kept: assert property (p_size_code_kept)
        else $error("page size code 3 was accepted");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("register read data stood beyond its cycle");

    property p_instr_answer_time;
        ibus_req.valid |-> ##3 ibus_resp.ack;
    endproperty
    a_instr_answer_time: assert property (p_instr_answer_time)
        else $error("instruction answer not three cycles after request");

    property p_deny_logged;
        dbus_req.valid && !d_allow
            |=> st.last_deny == {1'b0, $past(dbus_req.addr[16:0])};
    endproperty
    a_deny_logged: assert property (p_deny_logged)
        else $error("refused data access not logged");

    property p_instr_4k_remainder;
        ibus_req.valid && st.imode == MODE_4K && ibus_req.addr[16]
            |-> !i_managed;
    endproperty
    a_instr_4k_remainder: assert property (p_instr_4k_remainder)
        else $error("4 KB remainder treated as managed");

endmodule
`default_nettype wire

// *** design/ipmmu_xlate.sv ***
// access decision and page translation for one region
`timescale 1ns/1ps
`default_nettype none
module ipmmu_xlate import ipmmu_pkg::*; #(
    parameter logic [31:0] BASE = INSTR_BASE,
    parameter logic WRITE_OK = 1'b0
) (
    input wire logic [1:0] mode,
    input wire ipmmu_table_type tab,
    input wire logic [2:0] pid,
    input wire logic [31:0] addr,
    input wire logic wr,
    output logic allow,
    output logic managed,
    output logic [REGION_BITS-1:0] phys_addr
);
    logic [REGION_BITS-1:0] off;
    logic [REGION_BITS-1:0] shifted;
    logic [REGION_BITS-1:0] pmask;
    logic [4:0] sh;
    logic [3:0] vpage;
    logic [3:0] ppage;
    logic hit;
    logic in_region;

    always_comb begin
        in_region = (addr[31:REGION_BITS] == BASE[31:REGION_BITS]);
        off = addr[REGION_BITS-1:0];
        sh = ipmmu_page_shift(mode);
        shifted = off >> sh;
        vpage = shifted[3:0];
        // sixteen pages only, the rest of the region stays untranslated
        managed = ((off >> (sh + 5'h4)) == '0);
        hit = 1'b0;
        ppage = vpage;
        // lowest physical page wins if software maps one page twice
        for (int i = NUM_PAGES - 1; i >= 0; i--) begin
            if (tab[i].vpage == vpage && ipmmu_perm_ok(tab[i].perm, pid)) begin
                hit = 1'b1;
                ppage = 4'(i);
            end
        end
        if (pid < PRIV_LIMIT) begin
            ppage = vpage;
            allow = in_region;
        end else begin
            allow = in_region && managed && hit && (!wr || WRITE_OK);
        end
        pmask = 17'h0000f << sh;
        phys_addr = (off & ~pmask) | (17'(ppage) << sh);
    end
endmodule
`default_nettype wire
